// ===== decade_binary_stage.sv
// First binary stage of a counting decade with digit decoder and rate forcing
//
// Overview of operation
// - Every counted pulse reverses the toggle stage
// - Ten digit lines from toggle and quinary lines
// - Each digit line is a pure conjunction outside rate forcing
// - Odd maps a-e to 1..9, even to 0..8
// - Exactly one digit line active at once outside reset
// - Fast counting holds the zero digit line
// - Rate detector rises 120-170, falls 50-30 c/s
// - Stopped gate passes nothing, no rate forcing
// - Carry pulse feeds the divide-by-five stage
// - Reset forces toggle stage to initial state
`timescale 1ns/1ns
module decade_binary_stage #(
    parameter int WINDOW_CYCLES = decade_pkg::WINDOW_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_count_pulse,
    input wire logic i_interrogate_pulse,
    input wire logic i_input_gate_control,
    input wire logic [4:0] i_quinary,
    output logic o_toggle_odd,
    output logic o_toggle_even,
    output logic o_carry,
    output logic o_rate_detector_output,
    output logic [9:0] o_digit
);

    // ==========================================================
    // Input gate
    // ==========================================================
    decade_pkg::toggle_state_t toggle_stage_r;
    decade_pkg::toggle_state_t toggle_stage_nxt;
    logic counted;
    logic fast;
    logic [9:0] digit_nxt;
    logic [9:0] decoded;

    // Counted pulses pass only while the gate is open; read-out
    // pulses share the path after the gate
    assign counted = (i_count_pulse && i_input_gate_control) || i_interrogate_pulse;

    // ==========================================================
    // Toggle stage
    // ==========================================================
    always_comb begin
        toggle_stage_nxt = toggle_stage_r;
        if (counted) begin
            unique case (toggle_stage_r)
                decade_pkg::TOGGLE_EVEN: toggle_stage_nxt = decade_pkg::TOGGLE_ODD;
                decade_pkg::TOGGLE_ODD: toggle_stage_nxt = decade_pkg::TOGGLE_EVEN;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            toggle_stage_r <= decade_pkg::TOGGLE_RESET;
        end else begin
            toggle_stage_r <= toggle_stage_nxt;
        end
    end

    // Both state lines are registered copies of the stage
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_toggle_odd <= 1'b0;
            o_toggle_even <= 1'b1;
        end else begin
            o_toggle_odd <= (toggle_stage_nxt == decade_pkg::TOGGLE_ODD);
            o_toggle_even <= (toggle_stage_nxt == decade_pkg::TOGGLE_EVEN);
        end
    end

    // ==========================================================
    // Carry to the divide-by-five stage
    // ==========================================================
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_carry <= 1'b0;
        end else begin
            o_carry <= counted && (toggle_stage_r == decade_pkg::TOGGLE_ODD);
        end
    end

    // ==========================================================
    // Rate detector
    // ==========================================================
    decade_rate_detector #(
        .WINDOW_CYCLES(WINDOW_CYCLES)
    ) decade_rate_detector_inst (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_pulse(i_count_pulse && i_input_gate_control),
        .i_enable(i_input_gate_control),
        .o_fast(fast)
    );

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_rate_detector_output <= 1'b0;
        end else begin
            o_rate_detector_output <= fast && i_input_gate_control;
        end
    end

    // ==========================================================
    // Digit decoder
    // ==========================================================
    // Odd digit of pair k is odd line and quinary line k; even
    // digit is even line and quinary line k
    generate
        for (genvar k = 0; k < decade_pkg::QUINARY_COUNT; k++) begin : g_pair
            assign decoded[2*k+1] = (toggle_stage_r == decade_pkg::TOGGLE_ODD) && i_quinary[k];
            assign decoded[2*k] = (toggle_stage_r == decade_pkg::TOGGLE_EVEN) && i_quinary[k];
        end
    endgenerate

    // Forcing shows only the zero position so one line stays lit
    always_comb begin
        if (fast && i_input_gate_control) begin
            digit_nxt = decade_pkg::DIGIT_ZERO_ONLY;
        end else begin
            digit_nxt = decoded;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_digit <= decade_pkg::DIGIT_RESET;
        end else begin
            o_digit <= digit_nxt;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    chk_toggle_reverses_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        counted |=> (toggle_stage_r != $past(toggle_stage_r)))
        else $error("toggle stage did not reverse on a counted pulse");

    chk_toggle_holds_idle: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !counted |=> $stable(toggle_stage_r))
        else $error("toggle stage changed without a pulse");

    chk_state_lines_complement: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        ##1 (o_toggle_odd != o_toggle_even) && (o_toggle_odd == (toggle_stage_r == decade_pkg::TOGGLE_ODD)))
        else $error("state lines disagree with the toggle stage");

    chk_carry_on_odd: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_carry |-> $past(counted) && ($past(toggle_stage_r) == decade_pkg::TOGGLE_ODD))
        else $error("carry without an odd to even transition");

    chk_carry_issued: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (counted && toggle_stage_r == decade_pkg::TOGGLE_ODD) |=> o_carry && (toggle_stage_r == decade_pkg::TOGGLE_EVEN))
        else $error("odd to even transition gave no carry");

    chk_digit_decode_map: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !(fast && i_input_gate_control) && (toggle_stage_r == decade_pkg::TOGGLE_ODD) && i_quinary[2]
        |=> o_digit[5] && !o_digit[4])
        else $error("odd state with line c did not select digit 5");

    chk_digit_conjunction: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (!(fast && i_input_gate_control) && !i_quinary[3]) |=> !o_digit[6] && !o_digit[7])
        else $error("digit line active without its quinary line");

    chk_digit_onehot: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_reset_n && $onehot(i_quinary) |=> $onehot(o_digit))
        else $error("more or fewer than one digit line active");

    chk_zero_forced: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (fast && i_input_gate_control) |=> (o_digit == decade_pkg::DIGIT_ZERO_ONLY) && o_rate_detector_output)
        else $error("fast counting did not force the zero line");

    chk_stop_no_forcing: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !i_input_gate_control ##1 !i_input_gate_control |-> !o_rate_detector_output && !fast)
        else $error("rate forcing survived a closed gate");

    chk_stop_holds_count: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (!i_input_gate_control && !i_interrogate_pulse) |=> $stable(toggle_stage_r))
        else $error("closed gate let a pulse through");

    chk_reset_even: assert property (@(posedge i_clk_sys)
        !i_reset_n |=> (toggle_stage_r == decade_pkg::TOGGLE_EVEN) && o_toggle_even && !o_carry)
        else $error("reset did not force the even state");

    chk_reset_clears_out: assert property (@(posedge i_clk_sys)
        !i_reset_n |=> (o_digit == decade_pkg::DIGIT_RESET) && !o_rate_detector_output && !o_toggle_odd)
        else $error("reset left a digit, forcing or odd line active");

    chk_release_shows_zero: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        ($rose(i_reset_n) && (i_quinary == 5'h01)) |=> (o_digit == decade_pkg::DIGIT_ZERO_ONLY))
        else $error("first decode after reset was not digit 0");

    chk_carry_single_cycle: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_carry |=> !o_carry)
        else $error("carry pulse lasted more than one cycle");

    chk_carry_needs_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !counted |=> !o_carry)
        else $error("carry without a counted pulse");

    chk_carry_with_even: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_carry |-> o_toggle_even && !o_toggle_odd)
        else $error("carry did not coincide with the even state");

    chk_even_gives_odd: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (counted && toggle_stage_r == decade_pkg::TOGGLE_EVEN) |=> o_toggle_odd && !o_toggle_even && !o_carry)
        else $error("even to odd transition misbehaved");

    chk_pulses_pair_return: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        counted ##1 counted |=> (toggle_stage_r == $past(toggle_stage_r, 2)))
        else $error("two pulses did not return the toggle stage");

    chk_lines_idle_stable: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !counted |=> $stable(o_toggle_odd) && $stable(o_toggle_even))
        else $error("state lines moved without a pulse");

    chk_gate_blocks_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_count_pulse && !i_input_gate_control && !i_interrogate_pulse) |=> $stable(toggle_stage_r) && !o_carry)
        else $error("pulse passed a closed gate");

    chk_readout_counts: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_interrogate_pulse && !i_input_gate_control) |=> (toggle_stage_r != $past(toggle_stage_r)))
        else $error("read-out pulse did not reverse the stage");

    chk_forced_shows_zero: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_rate_detector_output |-> (o_digit == decade_pkg::DIGIT_ZERO_ONLY))
        else $error("forcing flag without the zero line alone");

    chk_forcing_needs_gate: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_rate_detector_output |-> $past(i_input_gate_control))
        else $error("forcing flag raised with the gate closed");

    chk_even_hides_odd: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (!(fast && i_input_gate_control) && toggle_stage_r == decade_pkg::TOGGLE_EVEN)
        |=> ((o_digit & 10'h2AA) == 10'h000))
        else $error("odd digit lit in the even state");

    chk_odd_hides_even: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (!(fast && i_input_gate_control) && toggle_stage_r == decade_pkg::TOGGLE_ODD)
        |=> ((o_digit & 10'h155) == 10'h000))
        else $error("even digit lit in the odd state");

    chk_digit_zero_map: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_reset_n && !(fast && i_input_gate_control) && (toggle_stage_r == decade_pkg::TOGGLE_EVEN) && i_quinary[0]
        |=> o_digit[0] && !o_digit[1])
        else $error("even state with line a did not select digit 0");

    chk_digit_one_map: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_reset_n && !(fast && i_input_gate_control) && (toggle_stage_r == decade_pkg::TOGGLE_ODD) && i_quinary[0]
        |=> o_digit[1] && !o_digit[0])
        else $error("odd state with line a did not select digit 1");

    chk_digit_eight_map: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_reset_n && !(fast && i_input_gate_control) && (toggle_stage_r == decade_pkg::TOGGLE_EVEN) && i_quinary[4]
        |=> o_digit[8] && !o_digit[9])
        else $error("even state with line e did not select digit 8");

    chk_digit_nine_map: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_reset_n && !(fast && i_input_gate_control) && (toggle_stage_r == decade_pkg::TOGGLE_ODD) && i_quinary[4]
        |=> o_digit[9] && !o_digit[8])
        else $error("odd state with line e did not select digit 9");

endmodule

// ===== decade_binary_stage_test.sv
// Self-checking testbench for the decade binary stage
`timescale 1ns/1ns
module decade_binary_stage_test;
    localparam int WIN = 100;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic count_pulse = 1'b0;
    logic interrogate = 1'b0;
    logic gate = 1'b0;
    logic [4:0] quinary;
    logic toggle_odd, toggle_even, carry, fast;
    logic [9:0] digit;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    int n = 0;

    always #25 clk = ~clk;

    decade_binary_stage #(.WINDOW_CYCLES(WIN)) decade_binary_stage_inst (.i_clk_sys(clk), .i_reset_n(reset_n),
        .i_count_pulse(count_pulse), .i_interrogate_pulse(interrogate), .i_input_gate_control(gate),
        .i_quinary(quinary), .o_toggle_odd(toggle_odd), .o_toggle_even(toggle_even), .o_carry(carry),
        .o_rate_detector_output(fast), .o_digit(digit));
    quinary_stage_model quinary_stage_model_inst (.i_clk_sys(clk), .i_reset_n(reset_n), .i_carry(carry),
        .o_quinary(quinary));

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic check(input logic [9:0] seen, input logic [9:0] expected);
        tests_run++;
        if (seen !== expected) begin
            n_mismatch++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic give_verdict();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Digit expected for a decade that has counted the given number of pulses
    function automatic logic [9:0] exp_digit(input int count);
        exp_digit = 10'h001 << ((count / 2) % 5 * 2 + count % 2);
    endfunction

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic one_pulse();
        @(posedge clk);
        count_pulse <= 1'b1;
        @(posedge clk);
        count_pulse <= 1'b0;
        #1;
        n++;
        check({9'h000, carry}, {9'h000, 1'(n % 2 == 0)});
        check({9'h000, toggle_odd}, {9'h000, 1'(n % 2)});
        check({9'h000, toggle_even}, {9'h000, 1'(n % 2 == 0)});
        tick(8);
        check({9'h000, carry}, 10'h000);
        check(digit, exp_digit(n));
    endtask

    task automatic burst(input int len);
        @(posedge clk);
        count_pulse <= 1'b1;
        repeat (len) @(posedge clk);
        count_pulse <= 1'b0;
        n += len;
        #1;
    endtask

    task automatic wait_fast(input logic expected, input int bound);
        int i;
        for (i = 0; i < bound && fast !== expected; i++) tick(1);
        check({9'h000, fast}, {9'h000, expected});
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic test_reset();
        tick(2);
        check({8'h00, toggle_even, toggle_odd}, 10'h002);
        check({8'h00, carry, fast}, 10'h000);
        check(digit, decade_pkg::DIGIT_ZERO_ONLY);
    endtask

    task automatic test_counting();
        int i;
        @(posedge clk);
        gate <= 1'b1;
        for (i = 0; i < 12; i++) one_pulse();
        check({9'h000, fast}, 10'h000);
    endtask

    task automatic test_gate_closed();
        @(posedge clk);
        gate <= 1'b0;
        burst(5);
        n -= 5;
        tick(4);
        check({9'h000, toggle_odd}, {9'h000, 1'(n % 2)});
        @(posedge clk);
        interrogate <= 1'b1;
        @(posedge clk);
        interrogate <= 1'b0;
        n++;
        tick(4);
        check({9'h000, toggle_odd}, {9'h000, 1'(n % 2)});
        check(digit, exp_digit(n));
    endtask

    task automatic test_rate_hysteresis();
        int i;
        @(posedge clk);
        gate <= 1'b1;
        burst(WIN + 20);
        wait_fast(1'b1, 3 * WIN);
        tick(2);
        check(digit, decade_pkg::DIGIT_ZERO_ONLY);
        for (i = 0; i < 25; i++) begin
            burst(1);
            tick(8);
        end
        check({9'h000, fast}, 10'h001);
        wait_fast(1'b0, 3 * WIN);
        tick(3);
        check(digit, exp_digit(n));
    endtask

    task automatic test_stop_clears();
        burst(WIN + 20);
        wait_fast(1'b1, 3 * WIN);
        @(posedge clk);
        gate <= 1'b0;
        tick(4);
        check({9'h000, fast}, 10'h000);
        check(digit, exp_digit(n));
    endtask

    task automatic test_reset_mid();
        @(posedge clk);
        gate <= 1'b1;
        if (n % 2 == 0) one_pulse();
        @(posedge clk);
        reset_n <= 1'b0;
        tick(2);
        check({8'h00, toggle_even, toggle_odd}, 10'h002);
        check(digit, decade_pkg::DIGIT_RESET);
        @(posedge clk);
        reset_n <= 1'b1;
        n = 0;
        tick(2);
        check(digit, exp_digit(0));
    endtask

    // ==========================================================
    // Main sequence and hang guard
    // ==========================================================
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        test_reset();
        test_counting();
        test_gate_closed();
        test_rate_hysteresis();
        test_stop_clears();
        test_reset_mid();
        give_verdict();
    end
endmodule

// ===== decade_pkg.sv
// Constants and types shared by the decade binary stage and its rate detector
package decade_pkg;

    // ==========================================================
    // Clock and counting structure
    // ==========================================================
    localparam int CLK_HZ = 20_000_000;
    localparam int DIGIT_COUNT = 10;
    localparam int QUINARY_COUNT = 5;

    // ==========================================================
    // Rate detector timing
    // ==========================================================
    // Measurement window, in milliseconds
    localparam int WINDOW_MS = 100;
    localparam int WINDOW_CYCLES = (CLK_HZ / 1000) * WINDOW_MS;
    // Rising threshold lies inside the 120 to 170 c/s band
    localparam int RISE_RATE_CPS = 140;
    // Falling threshold lies inside the 50 to 30 c/s band
    localparam int FALL_RATE_CPS = 40;
    localparam int RISE_COUNT = (RISE_RATE_CPS * WINDOW_MS) / 1000;
    localparam int FALL_COUNT = (FALL_RATE_CPS * WINDOW_MS) / 1000;
    localparam int PULSE_CNT_W = 16;
    localparam int WINDOW_CNT_W = 24;

    // ==========================================================
    // Toggle stage
    // ==========================================================
    typedef enum logic [0:0] {
        TOGGLE_EVEN = 1'h0,
        TOGGLE_ODD = 1'h1
    } toggle_state_t;

    localparam toggle_state_t TOGGLE_RESET = TOGGLE_EVEN;
    localparam logic [9:0] DIGIT_ZERO_ONLY = 10'h001;
    localparam logic [9:0] DIGIT_RESET = 10'h000;

endpackage

// ===== decade_rate_detector.sv
// Pulse rate detector with hysteresis that flags fast counting
`timescale 1ns/1ns
module decade_rate_detector #(
    parameter int WINDOW_CYCLES = decade_pkg::WINDOW_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_pulse,
    input wire logic i_enable,
    output logic o_fast
);

    logic [decade_pkg::WINDOW_CNT_W-1:0] window_cnt_r;
    logic [decade_pkg::PULSE_CNT_W-1:0] pulse_cnt_r;
    logic window_end;
    logic [decade_pkg::PULSE_CNT_W-1:0] total;

    localparam logic [decade_pkg::PULSE_CNT_W-1:0] RISE_N = decade_pkg::PULSE_CNT_W'(decade_pkg::RISE_COUNT);
    localparam logic [decade_pkg::PULSE_CNT_W-1:0] FALL_N = decade_pkg::PULSE_CNT_W'(decade_pkg::FALL_COUNT);
    localparam logic [decade_pkg::WINDOW_CNT_W-1:0] WIN_LAST = decade_pkg::WINDOW_CNT_W'(WINDOW_CYCLES - 1);

    assign window_end = (window_cnt_r == WIN_LAST);
    assign total = (pulse_cnt_r == '1) ? pulse_cnt_r : pulse_cnt_r + {{(decade_pkg::PULSE_CNT_W-1){1'b0}}, i_pulse};

    // ==========================================================
    // Window divider: one-cycle enable at the end of each window
    // ==========================================================
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n || !i_enable || window_end) begin
            window_cnt_r <= '0;
        end else begin
            window_cnt_r <= window_cnt_r + 1'b1;
        end
    end

    // ==========================================================
    // Pulses seen in the current window, saturating
    // ==========================================================
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n || !i_enable || window_end) begin
            pulse_cnt_r <= '0;
        end else begin
            pulse_cnt_r <= total;
        end
    end

    // ==========================================================
    // Hysteresis decision, dropped at once when counting stops
    // ==========================================================
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n || !i_enable) begin
            o_fast <= 1'b0;
        end else if (window_end) begin
            if (total >= RISE_N) begin
                o_fast <= 1'b1;
            end else if (total <= FALL_N) begin
                o_fast <= 1'b0;
            end
        end
    end

    chk_fast_needs_window: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(o_fast) |-> $past(window_end) && ($past(total) >= RISE_N))
        else $error("fast flag rose outside a window end or below threshold");

    chk_fast_release_hyst: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $fell(o_fast) |-> !$past(i_enable) || ($past(window_end) && ($past(total) <= FALL_N)))
        else $error("fast flag fell inside the hysteresis band");

endmodule

// ===== quinary_stage_model.sv
// Behavioural divide-by-five stage that answers the decade's carry
`timescale 1ns/1ns
module quinary_stage_model (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_carry,
    output logic [4:0] o_quinary
);
    // ==========================================================
    // One-hot ring a..e, advanced by each carry
    // ==========================================================
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_quinary <= 5'h01;
        end else if (i_carry) begin
            o_quinary <= {o_quinary[3:0], o_quinary[4]};
        end
    end
endmodule
